// ---- hw/difd_top.sv ----
// Purpose: digital IF chain: autorange, I/Q split, boost, Gaussian, decimate,
//          magnitude/phase, video smoothing and peak display detection
// Assumes: sample strobes on clk_sys_i; overload detector is an async pin
// Notes:   resolution index 0 is the narrowest bandwidth
// Contract
// R1: Cut analog gain quickly on impending overload
// R2: Raise analog gain after long small envelope
// R3: Digital gain inversely tracks analog gain
// R4: Ranging only when enabled and sweeping
// R5: Split samples into I/Q at half rate
// R6: Boost filter inverts single-pole prefilter
// R7: Linear-phase near-Gaussian low-pass on I/Q
// R8: Skirt follows near-Gaussian selectivity model
// R9: 160 digitally realised resolution bandwidths; the code maps the 160 indices onto 8 decimation steps
// R10: Decimate filtered pairs, forward to processor
// R11: Span limited to anti-alias bandwidth
// R12: Convert pairs to magnitude and phase
// R13: Video filter then display detector
// R14: Processor scales stored traces for display
// R15: Decimation chosen from span and bandwidth
`timescale 1ns/1ps
module difd_top #(
    parameter int SAMPLE_W = difd_pkg::SAMPLE_W,
    parameter int DW       = difd_pkg::DATA_W,
    parameter int BUCKET   = difd_pkg::BUCKET_LEN
) (
    input  wire logic                clk_sys_i,             // System clock
    input  wire logic                sys_rst_i,             // Sync reset, high
    input  wire logic signed [SAMPLE_W-1:0] adc_data_i,     // Converter sample
    input  wire logic                adc_valid_i,           // Sample strobe
    input  wire logic                ovl_detect_i,          // Overload pin, async
    input  wire logic                autorange_en_i,        // Ranging enable
    input  wire logic                swept_mode_i,          // Swept analysis
    input  wire logic [7:0]          resolution_bandwidth_i, // Index 0..159
    input  wire logic [2:0]          span_code_i,           // Span octave code
    input  wire logic [3:0]          video_bandwidth_i,     // Smoothing shift
    input  wire logic                fft_ready_i,           // Processor ready
    output logic [1:0]               analog_gain_o,         // Analog gain step
    output logic signed [DW-1:0]     fft_i_o,               // Decimated I
    output logic signed [DW-1:0]     fft_q_o,               // Decimated Q
    output logic                     fft_valid_o,           // Pair valid
    output logic [DW-1:0]            mag_o,                 // Magnitude
    output logic [2:0]               phase_oct_o,           // Phase octant
    output logic                     mag_valid_o,           // Magnitude strobe
    output logic [DW-1:0]            det_o,                 // Display point
    output logic                     det_valid_o,           // Point strobe
    output logic                     overrun_o              // Pair lost, sticky
);
    localparam int HOLD_W = $clog2(difd_pkg::SMALL_HOLD_CYC + 1);
    localparam int NS     = difd_pkg::GAUSS_STAGES;
    localparam int BKW    = $clog2(BUCKET + 1);
    localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(difd_pkg::SMALL_HOLD_CYC - 1);
    localparam logic [BKW-1:0]    BKT_LAST  = BKW'(BUCKET - 1);

    function automatic logic signed [DW-1:0] mag_of(input logic signed [DW-1:0] x);
        return x[DW-1] ? -x : x;
    endfunction

    // Binomial 1-2-1 tap set: symmetric, so each stage keeps linear phase
    function automatic logic signed [DW-1:0] binom(input logic signed [DW-1:0] a,
                                                   input logic signed [DW-1:0] b,
                                                   input logic signed [DW-1:0] c);
        logic signed [DW+1:0] s;
        s = {{2{a[DW-1]}}, a} + {b[DW-1], b, 1'b0} + {{2{c[DW-1]}}, c};
        return s[DW+1:2];
    endfunction

    function automatic logic [2:0] decim_exp(input logic [7:0] res_bw,
                                             input logic [2:0] span);
        logic [7:0] r;
        logic [2:0] rc;
        r  = (res_bw >= 8'(difd_pkg::RES_BW_COUNT)) ? 8'(difd_pkg::RES_BW_COUNT - 1) : res_bw;
        rc = 3'((8'(difd_pkg::RES_BW_COUNT - 1) - r) / 8'(difd_pkg::RES_BW_PER_OCT));
        return (rc > span) ? rc : span;
    endfunction

    // Overload pin synchroniser; only stages 2 and 3 are looked at
    logic [2:0] ovl_sync_q;
    logic       ovl_seen_q;
    // A level counts only once stages 2 and 3 agree, so a one-cycle glitch is ignored
    wire ovl_hi   = (ovl_sync_q[1] == ovl_sync_q[2]) ? ovl_sync_q[2] : ovl_seen_q;
    wire range_on = autorange_en_i & swept_mode_i;

    logic signed [DW-1:0] adc_ext;
    assign adc_ext = {{(DW - SAMPLE_W){adc_data_i[SAMPLE_W-1]}}, adc_data_i};
    wire adc_small = mag_of(adc_ext) < DW'(difd_pkg::SMALL_THR);

    logic [1:0]        gain_q;
    logic [1:0]        gain_d;
    logic [1:0]        gain_dly_q;
    logic [HOLD_W-1:0] hold_q;
    logic [HOLD_W-1:0] hold_d;

    wire gain_cut = range_on & ovl_hi & (gain_q != difd_pkg::GAIN_MIN);           // R1 R4
    wire gain_up  = range_on & ~ovl_hi & adc_valid_i & adc_small                 // R4
                  & (hold_q == HOLD_LAST) & (gain_q != difd_pkg::GAIN_MAX);     // R2
    assign gain_d = gain_cut ? gain_q - difd_pkg::GAIN_ONE :                      // R1
                    gain_up  ? gain_q + difd_pkg::GAIN_ONE : gain_q;              // R2
    // Any large sample or overload restarts the quiet-time count
    assign hold_d = (~range_on | ovl_hi | gain_up) ? '0 :
                    ~adc_valid_i ? hold_q :
                    ~adc_small ? '0 :
                    (hold_q == HOLD_LAST) ? hold_q : hold_q + HOLD_W'(1'b1);     // R2

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            ovl_sync_q <= 3'h0;
            ovl_seen_q <= 1'b0;
            gain_q     <= difd_pkg::GAIN_RST;
            gain_dly_q <= difd_pkg::GAIN_RST;
            hold_q     <= '0;
        end else begin
            ovl_sync_q <= {ovl_sync_q[1:0], ovl_detect_i};
            ovl_seen_q <= ovl_hi;
            gain_q     <= gain_d;
            gain_dly_q <= gain_q;
            hold_q     <= hold_d;
        end
    end
    assign analog_gain_o = gain_q;

    // Samples arrive one cycle after a gain change, so the shift uses the delayed step
    logic signed [DW-1:0] comp_q;
    logic                 comp_v_q;
    wire [1:0] comp_sh = difd_pkg::GAIN_MAX - gain_dly_q;                         // R3

    logic [1:0]           iq_ph_q;
    logic signed [DW-1:0] i_hold_q;
    logic signed [DW-1:0] pair_q [2];
    logic                 pair_v_q;
    logic signed [DW-1:0] flip;
    assign flip = iq_ph_q[1] ? -comp_q : comp_q;                                  // R5

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            comp_q   <= '0;
            comp_v_q <= 1'b0;
            iq_ph_q  <= 2'h0;
            i_hold_q <= '0;
            pair_q   <= '{default: '0};
            pair_v_q <= 1'b0;
        end else begin
            comp_v_q <= adc_valid_i;
            if (adc_valid_i) begin
                comp_q <= adc_ext <<< comp_sh;                                    // R3
            end
            pair_v_q <= comp_v_q & iq_ph_q[0];                                    // R5
            if (comp_v_q) begin
                iq_ph_q <= iq_ph_q + 2'h1;
                if (!iq_ph_q[0]) begin
                    i_hold_q <= flip;
                end else begin
                    pair_q[0] <= i_hold_q;
                    pair_q[1] <= flip;
                end
            end
        end
    end

    // One-zero boost lifts the high end that the prefilter pole rolled off
    logic signed [DW-1:0] prev_q  [2];
    logic signed [DW-1:0] boost_q [2];
    logic signed [DW-1:0] boost_d [2];
    logic                 boost_v_q;
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            boost_d[c] = pair_q[c] + ((pair_q[c] - prev_q[c]) >>> difd_pkg::BOOST_SH); // R6
        end
    end

    logic signed [DW-1:0] g_in   [2][NS];
    logic signed [DW-1:0] g_t1_q [2][NS];
    logic signed [DW-1:0] g_t2_q [2][NS];
    logic signed [DW-1:0] g_y_q  [2][NS];
    logic                 g_v_q;
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            g_in[c][0] = boost_q[c];
            for (int s = 1; s < NS; s++) begin
                g_in[c][s] = g_y_q[c][s-1];
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            prev_q    <= '{default: '0};
            boost_q   <= '{default: '0};
            boost_v_q <= 1'b0;
            g_t1_q    <= '{default: '{default: '0}};
            g_t2_q    <= '{default: '{default: '0}};
            g_y_q     <= '{default: '{default: '0}};
            g_v_q     <= 1'b0;
        end else begin
            boost_v_q <= pair_v_q;
            g_v_q     <= boost_v_q;
            if (pair_v_q) begin
                prev_q  <= pair_q;
                boost_q <= boost_d;                                               // R6
            end
            // Cascaded binomial stages converge on a Gaussian shape
            if (boost_v_q) begin
                for (int c = 0; c < 2; c++) begin
                    for (int s = 0; s < NS; s++) begin
                        g_t1_q[c][s] <= g_in[c][s];
                        g_t2_q[c][s] <= g_t1_q[c][s];
                        g_y_q[c][s]  <= binom(g_in[c][s], g_t1_q[c][s], g_t2_q[c][s]); // R7 R8
                    end
                end
            end
        end
    end

    // Bandwidth is set by the decimation that follows the fixed Gaussian kernel
    logic [2:0] dec_exp;
    logic [7:0] dec_len_m1;
    logic [7:0] dec_cnt_q;
    logic       dec_v_q;
    logic signed [DW-1:0] dec_i_q;
    logic signed [DW-1:0] dec_qd_q;
    assign dec_exp    = decim_exp(resolution_bandwidth_i, span_code_i);           // R9 R15
    assign dec_len_m1 = (8'h01 << dec_exp) - 8'h01;                               // R11

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            dec_cnt_q <= 8'h00;
            dec_v_q   <= 1'b0;
            dec_i_q   <= '0;
            dec_qd_q  <= '0;
        end else begin
            dec_v_q <= 1'b0;
            if (g_v_q) begin
                // Compare with >= so a shorter factor mid-count cannot wedge it
                if (dec_cnt_q >= dec_len_m1) begin
                    dec_cnt_q <= 8'h00;
                    dec_v_q   <= 1'b1;                                            // R10 R15
                    dec_i_q   <= g_y_q[0][NS-1];
                    dec_qd_q  <= g_y_q[1][NS-1];
                end else begin
                    dec_cnt_q <= dec_cnt_q + 8'h01;
                end
            end
        end
    end

    logic            buf_rdy;
    logic [2*DW-1:0] fft_word;
    logic            overrun_q;
    difd_buf #(
        .WIDTH(2 * DW)
    ) u_buf (
        .clk_sys_i   (clk_sys_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (dec_v_q),
        .in_data_i   ({dec_i_q, dec_qd_q}),
        .in_ready_o  (buf_rdy),
        .out_valid_o (fft_valid_o),
        .out_data_o  (fft_word),
        .out_ready_i (fft_ready_i)
    );                                                                            // R10
    assign fft_i_o   = fft_word[2*DW-1:DW];
    assign fft_q_o   = fft_word[DW-1:0];
    assign overrun_o = overrun_q;

    // Max plus half min: cheap magnitude within about ten percent
    logic signed [DW-1:0] ai;
    logic signed [DW-1:0] aq;
    logic signed [DW-1:0] big;
    logic signed [DW-1:0] sml;
    assign ai  = mag_of(dec_i_q);
    assign aq  = mag_of(dec_qd_q);
    assign big = (ai >= aq) ? ai : aq;
    assign sml = (ai >= aq) ? aq : ai;

    logic [DW-1:0] mag_q;
    logic [2:0]    phase_q;
    logic          mag_v_q;
    logic [DW-1:0] video_q;
    logic          video_v_q;
    logic [DW-1:0] peak_q;
    logic [DW-1:0] peak_n;
    logic [BKW-1:0] bkt_q;
    logic [DW-1:0] det_q;
    logic          det_v_q;
    logic signed [DW:0] video_err;
    assign video_err = $signed({1'b0, mag_q}) - $signed({1'b0, video_q});
    assign peak_n = (bkt_q == '0 || video_q > peak_q) ? video_q : peak_q;        // R13

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            overrun_q <= 1'b0;
            mag_q     <= '0;
            phase_q   <= 3'h0;
            mag_v_q   <= 1'b0;
            video_q   <= '0;
            video_v_q <= 1'b0;
            peak_q    <= '0;
            bkt_q     <= '0;
            det_q     <= '0;
            det_v_q   <= 1'b0;
        end else begin
            overrun_q <= overrun_q | (dec_v_q & ~buf_rdy);
            mag_v_q   <= dec_v_q & swept_mode_i;
            video_v_q <= mag_v_q;
            det_v_q   <= 1'b0;
            if (dec_v_q) begin
                mag_q   <= DW'(big + (sml >>> 1));                                // R12
                phase_q <= {dec_i_q[DW-1], dec_qd_q[DW-1], aq > ai};              // R12
            end
            if (mag_v_q) begin
                video_q <= video_q + DW'(video_err >>> video_bandwidth_i);        // R13
            end
            if (video_v_q) begin
                peak_q <= peak_n;
                if (bkt_q == BKT_LAST) begin
                    bkt_q   <= '0;
                    det_q   <= peak_n;                                            // R13
                    det_v_q <= 1'b1;
                end else begin
                    bkt_q <= bkt_q + BKW'(1'b1);
                end
            end
        end
    end
    assign mag_o       = mag_q;
    assign phase_oct_o = phase_q;
    assign mag_valid_o = mag_v_q;
    assign det_o       = det_q;
    assign det_valid_o = det_v_q;

    default clocking d_cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_ovl_req;
        range_on && ovl_hi && gain_q != difd_pkg::GAIN_MIN;
    endsequence
    sequence s_gain_cut;
        gain_q == $past(gain_q) - difd_pkg::GAIN_ONE;
    endsequence

    a_ovl_cut: // R1
        assert property (s_ovl_req |=> s_gain_cut) else $error("gain not cut on overload");
    a_ovl_lead: // R1
        assert property (($rose(ovl_sync_q[1]) ##1 s_ovl_req) |-> ##1 gain_q < $past(gain_q))
        else $error("gain cut late after overload pin");
    a_gain_raise: // R2
        assert property (gain_q > $past(gain_q) |-> $past(hold_q) == HOLD_LAST && $past(adc_small))
        else $error("gain raised without quiet time");
    a_range_off: // R4
        assert property (!range_on |=> $stable(gain_q)) else $error("gain moved while off");
    a_comp_track: // R3
        assert property (comp_v_q |-> comp_q == ($past(adc_ext) <<< (difd_pkg::GAIN_MAX
                         - $past(gain_dly_q)))) else $error("digital gain mismatch");
    a_pair_rate: // R5
        assert property (pair_v_q |=> !pair_v_q) else $error("pairs faster than half rate");
    a_fft_hold: // R10
        assert property (fft_valid_o && !fft_ready_i |=> fft_valid_o && $stable(fft_i_o)
                         && $stable(fft_q_o)) else $error("pair dropped under stall");
    a_dec_factor: // R15
        assert property (dec_v_q |-> $past(dec_cnt_q) >= $past(dec_len_m1))
        else $error("decimator emitted early");
    a_mag_bound: // R12
        assert property (mag_v_q |-> mag_q >= $past(ai) && mag_q >= $past(aq))
        else $error("magnitude below component");
    a_det_peak: // R13
        assert property (det_v_q |-> det_q >= $past(video_q)) else $error("detector missed peak");
endmodule

// ---- hw/difd_pkg.sv ----
// Purpose: shared constants of the digital IF datapath
// Assumes: one system clock, sample strobes on that clock
// Notes:   gain steps count upward; a higher step is more analog gain
package difd_pkg;
    localparam int         SAMPLE_W       = 14;
    localparam int         DATA_W         = 20;
    localparam logic [1:0] GAIN_MIN       = 2'h0;
    localparam logic [1:0] GAIN_MAX       = 2'h3;
    localparam logic [1:0] GAIN_RST       = 2'h3;
    localparam logic [1:0] GAIN_ONE       = 2'h1;
    localparam int         CLK_HZ         = 10_000_000;
    localparam int         ADC_HZ         = 30_000_000;
    // Lead time of the anti-alias filter, in converter cycles
    localparam int         LEAD_CYC       = 3;
    localparam int         SMALL_HOLD_US  = 100;
    localparam int         SMALL_HOLD_CYC = SMALL_HOLD_US * (CLK_HZ / 1_000_000);
    localparam int         SMALL_THR      = 1024;
    localparam int         BOOST_SH       = 2;
    localparam int         GAUSS_STAGES   = 3;
    localparam int         RES_BW_COUNT   = 160;
    localparam int         RES_BW_PER_OCT = 20;
    localparam logic [2:0] SPAN_MAX_CODE  = 3'h7;
    localparam int         AAF_BW_HZ      = 10_000_000;
    localparam int         SEL_ALPHA_X100 = 212;
    localparam int         SEL_RATIO_X10  = 41;
    localparam int         BUCKET_LEN     = 8;
endpackage

// ---- hw/difd_buf.sv ----
// Purpose: two-entry skid buffer between decimator and processor
// Assumes: source and sink on the same clock
// Notes:   output word and valid come straight from flip-flops
`timescale 1ns/1ps
module difd_buf #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_sys_i,    // System clock
    input  wire logic             sys_rst_i,    // Synchronous reset, high
    input  wire logic             in_valid_i,   // Word offered
    input  wire logic [WIDTH-1:0] in_data_i,    // Offered word
    output logic                  in_ready_o,   // Room for a word
    output logic                  out_valid_o,  // Word available
    output logic      [WIDTH-1:0] out_data_o,   // Available word
    input  wire logic             out_ready_i   // Sink takes word
);
    logic             out_v_q;
    logic [WIDTH-1:0] out_d_q;
    logic             skid_v_q;
    logic [WIDTH-1:0] skid_d_q;

    wire take      = in_valid_i & ~skid_v_q;
    wire slot_free = ~out_v_q | out_ready_i;

    assign in_ready_o  = ~skid_v_q;
    assign out_valid_o = out_v_q;
    assign out_data_o  = out_d_q;

    // A stall parks at most one word in the skid entry; words offered while it is full are dropped
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            out_v_q  <= 1'b0;
            out_d_q  <= '0;
            skid_v_q <= 1'b0;
            skid_d_q <= '0;
        end else if (slot_free) begin
            if (skid_v_q) begin
                out_d_q  <= skid_d_q;
                skid_v_q <= 1'b0;
            end else begin
                out_v_q <= take;
                out_d_q <= take ? in_data_i : out_d_q;
            end
        end else if (take) begin
            skid_v_q <= 1'b1;
            skid_d_q <= in_data_i;
        end
    end
endmodule

// ---- test/difd_far.sv ----
// Purpose: far-side model: converter behind analog gain, and processor sink
// Assumes: controls come from the bench at the falling edge
// Notes:   each analog gain step is 6 dB, so the reading halves per step cut
`timescale 1ns/1ps
module difd_far (
    input  wire logic               clk_sys_i,   // System clock
    input  wire logic signed [13:0] level_i,     // Signal level at top gain
    input  wire logic               run_i,       // Stream samples
    input  wire logic               ovl_req_i,   // Impending large signal
    input  wire logic               stall_i,     // Processor busy
    input  wire logic        [1:0]  gain_i,      // Analog gain step
    input  wire logic               take_i,      // Pair offered
    input  wire logic signed [19:0] word_i,      // Offered I word
    output logic signed      [13:0] adc_data_o,  // Converter sample
    output logic                    adc_valid_o, // Sample strobe
    output logic                    ovl_o,       // Overload pin
    output logic                    ready_o      // Processor ready
);
    logic signed [13:0] scaled;
    logic signed [19:0] stored_q;
    logic        [1:0]  gain_seen_q = 2'h3;
    logic        [1:0]  tone_ph_q   = 2'h0;
    // The converter pipeline applies a gain change one sample late
    assign scaled      = level_i >>> (2'h3 - gain_seen_q);
    // Quarter-rate tone mixes down to a steady I/Q pair
    // Between strobes the bus carries junk so a stale sample cannot pass
    assign adc_data_o  = run_i ? (tone_ph_q[1] ? -scaled : scaled) : ~scaled;
    assign adc_valid_o = run_i;
    assign ovl_o       = ovl_req_i;
    assign ready_o     = ~stall_i;
    always @(posedge clk_sys_i) begin
        gain_seen_q <= gain_i;
        if (run_i) begin
            tone_ph_q <= tone_ph_q + 2'h1;
        end
    end
    // Stored linear; display scale is applied later on stored traces
    always_ff @(posedge clk_sys_i) begin
        if (take_i && ready_o) begin
            stored_q <= word_i;
        end
    end
endmodule

// ---- test/tb.sv ----
// Purpose: self-checking bench for the digital IF datapath
// Assumes: design and far-side model on one 10 MHz clock
// Notes:   output rates are counted over whole decimation periods
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin error_cnt++; $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module tb;
    logic               clk_sys_i = 1'b0;
    logic               sys_rst_i = 1'b1;
    logic signed [13:0] adc_data;
    logic               adc_valid;
    logic               ovl;
    logic               fft_ready;
    logic               en        = 1'b0;
    logic               swept     = 1'b0;
    logic        [7:0]  res_bw    = 8'h9f;
    logic        [2:0]  span      = 3'h0;
    logic signed [13:0] level     = 14'sh0400;
    logic               run       = 1'b0;
    logic               ovl_req   = 1'b0;
    logic               stall     = 1'b0;
    logic        [1:0]  gain;
    logic signed [19:0] fft_i;
    logic signed [19:0] fft_q;
    logic        [19:0] mag;
    logic        [2:0]  phase;
    logic        [19:0] det;
    logic               fft_valid;
    logic               mag_valid;
    logic               det_valid;
    logic               overrun;
    logic signed [19:0] held;
    int                 error_cnt = 0;
    int                 checks    = 0;
    int                 n_fft     = 0;
    int                 n_mag     = 0;
    int                 n_det     = 0;

    always #50 clk_sys_i = ~clk_sys_i;

    difd_top i_difd_top (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .adc_data_i(adc_data),
        .adc_valid_i(adc_valid), .ovl_detect_i(ovl), .autorange_en_i(en),
        .swept_mode_i(swept), .resolution_bandwidth_i(res_bw), .span_code_i(span),
        .video_bandwidth_i(4'h2), .fft_ready_i(fft_ready), .analog_gain_o(gain),
        .fft_i_o(fft_i), .fft_q_o(fft_q), .fft_valid_o(fft_valid), .mag_o(mag),
        .phase_oct_o(phase), .mag_valid_o(mag_valid), .det_o(det),
        .det_valid_o(det_valid), .overrun_o(overrun)
    );

    difd_far i_difd_far (
        .clk_sys_i(clk_sys_i), .level_i(level), .run_i(run), .ovl_req_i(ovl_req),
        .stall_i(stall), .gain_i(gain), .take_i(fft_valid), .word_i(fft_i),
        .adc_data_o(adc_data), .adc_valid_o(adc_valid), .ovl_o(ovl),
        .ready_o(fft_ready)
    );

    always @(posedge clk_sys_i) begin
        if (!sys_rst_i) begin
            n_fft = n_fft + int'(fft_valid && fft_ready);
            n_mag = n_mag + int'(mag_valid);
            n_det = n_det + int'(det_valid);
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask

    task automatic finish_test;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic t_reset;
        `CHK("gain at reset", 2'h3, gain)
        `CHK("valid at reset", 1'b0, fft_valid)
        `CHK("overrun at reset", 1'b0, overrun)
    endtask

    // One-cycle glitch is ignored; a held pin cuts on the fourth edge; no cut below 0
    task automatic t_cut;
        en = 1'b1;
        swept = 1'b1;
        ovl_req = 1'b1;
        cyc(1);
        ovl_req = 1'b0;
        cyc(4);
        `CHK("glitch ignored", 2'h3, gain)
        ovl_req = 1'b1;
        cyc(3);
        `CHK("gain before cut", 2'h3, gain)
        cyc(1);
        `CHK("gain after cut", 2'h2, gain)
        cyc(1);
        `CHK("next step", 2'h1, gain)
        cyc(4);
        ovl_req = 1'b0;
        cyc(6);
        `CHK("gain floor", 2'h0, gain)
    endtask

    task automatic t_raise;
        level = 14'sh0100;
        run = 1'b1;
        cyc(990);
        `CHK("gain held", 2'h0, gain)
        `CHK("output at low gain", 20'sh00100, fft_i)
        cyc(14);
        `CHK("gain raised", 2'h1, gain)
        cyc(20);
        `CHK("output after raise", 20'sh00100, fft_i)
        run = 1'b0;
        cyc(1);
    endtask

    task automatic t_freeze(input logic e, input logic s);
        en = e;
        swept = s;
        ovl_req = 1'b1;
        cyc(6);
        ovl_req = 1'b0;
        cyc(6);
        `CHK("gain frozen", 2'h1, gain)
    endtask

    task automatic t_rate(input logic [2:0] sp, input logic [7:0] idx,
                          input int ex, input logic sw);
        int per;
        per = 2 << ex;
        span = sp;
        res_bw = idx;
        swept = sw;
        run = 1'b1;
        cyc(600);
        n_fft = 0;
        n_mag = 0;
        n_det = 0;
        cyc(per * 8);
        `CHK("pairs out", 8, n_fft)
        `CHK("magnitudes", sw ? 8 : 0, n_mag)
        `CHK("display points", sw ? 1 : 0, n_det)
        `CHK("pair I", 20'sh00400, fft_i)
        `CHK("pair Q", 20'sh00400, fft_q)
        `CHK("magnitude", 20'h00600, mag)
        `CHK("phase octant", 3'h0, phase)
        `CHK("detector level", 1'b1, det >= 20'h005fd && det <= 20'h00600)
    endtask

    // Sink stalls: word holds, surplus pairs are dropped, two remain queued
    task automatic t_stall;
        span = 3'h0;
        res_bw = 8'h9f;
        stall = 1'b1;
        cyc(20);
        held = fft_i;
        cyc(10);
        `CHK("valid held", 1'b1, fft_valid)
        `CHK("word held", held, fft_i)
        `CHK("overrun set", 1'b1, overrun)
        run = 1'b0;
        cyc(12);
        n_fft = 0;
        stall = 1'b0;
        cyc(10);
        `CHK("drained pairs", 2, n_fft)
        `CHK("buffer empty", 1'b0, fft_valid)
        `CHK("overrun sticky", 1'b1, overrun)
    endtask

    initial begin
        cyc(4);
        sys_rst_i = 1'b0;
        t_reset();
        t_cut();
        t_raise();
        t_freeze(1'b0, 1'b1);
        t_freeze(1'b1, 1'b0);
        en = 1'b0;
        level = 14'sh0400;
        t_rate(3'h0, 8'h9f, 0, 1'b1);
        t_rate(3'h2, 8'h9f, 2, 1'b1);
        t_rate(3'h0, 8'h77, 2, 1'b1);
        t_rate(3'h1, 8'h00, 7, 1'b1);
        t_rate(3'h0, 8'hc8, 0, 1'b1);
        t_rate(3'h0, 8'h9f, 0, 1'b0);
        t_stall();
        finish_test();
    end

    initial begin
        #2000000;
        error_cnt++;
        finish_test();
    end
endmodule
